// ==== rtl/sool_pkg.sv ====
package sool_pkg;
    // clock rate and documented times
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CONTOUR_TOL_MM = 200;
    localparam int unsigned EDM_WIN_MS = 500;
    localparam int unsigned SIM_WIN_MS = 500;
    localparam int unsigned LINK_EXT_MS = 20;
    localparam int unsigned DLY_EXT_MS = 40;
    localparam int unsigned DLY_DEF_MS = 100;
    // derived cycle counts (exact at 125 MHz)
    localparam int unsigned EDM_WIN_CYC = EDM_WIN_MS * CYC_PER_MS;
    localparam int unsigned SIM_WIN_CYC = SIM_WIN_MS * CYC_PER_MS;
    localparam int unsigned LINK_EXT_CYC = LINK_EXT_MS * CYC_PER_MS;
    localparam int unsigned DLY_EXT_CYC = DLY_EXT_MS * CYC_PER_MS;
    localparam int unsigned DLY_DEF_CYC = DLY_DEF_MS * CYC_PER_MS;
    // widths
    localparam int CNT_W = 32;
    localparam int CONTOUR_W = 12;
    localparam int NFSEL = 10;
    localparam int NSIG_OUT = 4;
    localparam int SEL_W = 3;
    // error codes
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_EDM_OPEN = 4'h1;
    localparam logic [3:0] ERR_EDM_CLOSE = 4'h2;
    localparam logic [3:0] ERR_LINK_SIM = 4'h3;

    typedef enum logic [1:0] {
        LNK_OPEN = 2'b00,
        LNK_WAIT = 2'b01,
        LNK_CLOSED = 2'b10,
        LNK_BAD = 2'b11
    } sool_lnk_t;

    typedef enum logic [1:0] {
        EDM_IDLE = 2'b00,
        EDM_OPEN_CHK = 2'b01,
        EDM_CLOSE_CHK = 2'b10
    } sool_edm_t;

    // static configuration
    typedef struct packed {
        logic two_func;
        logic delay_en;
        logic edm_en;
        logic link_en;
        logic link_elec;
        logic [1:0] contour_en;
        logic [1:0] standby;
    } sool_cfg_t;

    // indication signals, bit 0 is diag
    typedef struct packed {
        logic pf_viol;
        logic wf_viol;
        logic chg_act;
        logic outputs_on;
        logic fault;
        logic error;
        logic warn;
        logic diag;
    } sool_ind_t;
endpackage

// ==== rtl/sool_interlock.sv ====
`timescale 1ns/1ps
`default_nettype none
module sool_interlock
    import sool_pkg::*;
#(
    parameter int unsigned EDM_CYC = EDM_WIN_CYC,
    parameter int unsigned SIM_CYC = SIM_WIN_CYC,
    parameter int unsigned LINK_CYC = LINK_EXT_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // configuration
    input wire sool_cfg_t cfg,
    input wire logic [CNT_W-1:0] cfg_delay_cyc,
    input wire logic [NSIG_OUT-1:0][SEL_W-1:0] sig_sel,
    // field evaluation
    input wire logic [1:0] pf_violation,
    input wire logic [1:0] wf_violation,
    input wire logic [1:0][CONTOUR_W-1:0] contour_dev_mm,
    input wire logic [NFSEL-1:0] field_select_inputs,
    // external circuits
    input wire logic contactor_feedback_input,
    input wire logic [1:0] link_ch,
    input wire logic fault_clear,
    // safety outputs and status
    output logic primary_safety_output_group,
    output logic secondary_safety_output_group,
    output logic fault_lock,
    output logic err_pulse,
    output logic [3:0] err_code,
    output sool_ind_t ind,
    output logic [NSIG_OUT-1:0] sig_out
);
    // reset release through two flops
    logic [1:0] rst_sync_reg;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // contour deviation faults per function
    logic [1:0] contour_fault;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            contour_fault[i] = cfg.contour_en[i] &&
                (contour_dev_mm[i] > CONTOUR_W'(CONTOUR_TOL_MM));
        end
    end

    // upstream linkage with simultaneity check
    sool_lnk_t lnk_reg, lnk_next;
    logic [CNT_W-1:0] sim_cnt_reg, sim_cnt_next, ext_cnt_reg, ext_cnt_next;
    logic both_closed, none_closed, lnk_fail, link_ok, link_permit;
    assign both_closed = &link_ch;
    assign none_closed = ~|link_ch;
    always_comb begin
        lnk_next = lnk_reg;
        sim_cnt_next = sim_cnt_reg;
        lnk_fail = 1'b0;
        unique case (lnk_reg)
            LNK_OPEN: begin
                sim_cnt_next = '0;
                if (both_closed) begin
                    lnk_next = LNK_CLOSED;
                end else if (!none_closed) begin
                    lnk_next = LNK_WAIT;
                end
            end
            LNK_WAIT: begin
                if (both_closed) begin
                    lnk_next = LNK_CLOSED;
                end else if (none_closed) begin
                    lnk_next = LNK_OPEN;
                end else if (sim_cnt_reg >= CNT_W'(SIM_CYC - 1)) begin
                    lnk_next = LNK_BAD;
                    lnk_fail = 1'b1;
                end else begin
                    sim_cnt_next = sim_cnt_reg + 1'b1;
                end
            end
            LNK_CLOSED: begin
                sim_cnt_next = '0;
                if (none_closed) begin
                    lnk_next = LNK_OPEN;
                end else if (!both_closed) begin
                    lnk_next = LNK_WAIT;
                end
            end
            LNK_BAD: begin
                if (none_closed) begin
                    lnk_next = LNK_OPEN;
                end
            end
        endcase
        // linked switch-off takes effect after the extension
        if (lnk_reg == LNK_CLOSED && lnk_next != LNK_CLOSED) begin
            ext_cnt_next = CNT_W'(LINK_CYC);
        end else if (lnk_next == LNK_CLOSED || ext_cnt_reg == '0) begin
            ext_cnt_next = '0;
        end else begin
            ext_cnt_next = ext_cnt_reg - 1'b1;
        end
    end
    assign link_ok = (lnk_reg == LNK_CLOSED) || (ext_cnt_reg != '0);
    assign link_permit = !cfg.link_en || link_ok;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk_reg <= LNK_OPEN;
            sim_cnt_reg <= '0;
            ext_cnt_reg <= '0;
        end else begin
            lnk_reg <= lnk_next;
            sim_cnt_reg <= sim_cnt_next;
            ext_cnt_reg <= ext_cnt_next;
        end
    end

    // output control, switch-off delay and feedback check
    logic pri_reg, pri_next, sec_reg, sec_next, fault_reg, fault_next;
    logic err_reg, err_next;
    logic [3:0] code_reg, code_next;
    logic [CNT_W-1:0] dly_reg, dly_next, edm_cnt_reg, edm_cnt_next;
    sool_edm_t edm_reg, edm_next;
    logic demand_a, demand_b, on_ok, any_on, any_on_next, edm_fail;
    always_comb begin
        demand_a = !pf_violation[0] && !contour_fault[0] && !cfg.standby[0] &&
            link_permit && !fault_reg;
        demand_b = cfg.two_func ? (!pf_violation[1] && !contour_fault[1] &&
            !cfg.standby[1] && link_permit && !fault_reg) : demand_a;
        // switch-on needs idle check, closed feedback, no running delay
        on_ok = (edm_reg == EDM_IDLE) && (dly_reg == '0) &&
            (!cfg.edm_en || contactor_feedback_input);
        pri_next = demand_a && (pri_reg || on_ok);
        dly_next = dly_reg;
        sec_next = demand_b && (sec_reg || on_ok);
        if (!cfg.two_func && cfg.delay_en && !fault_reg && !cfg.standby[0]) begin
            // secondary follows primary off after the set delay
            if (pri_reg && !demand_a && sec_reg && cfg_delay_cyc != '0) begin
                dly_next = cfg_delay_cyc;
                sec_next = 1'b1;
            end else if (dly_reg > CNT_W'(1)) begin
                dly_next = dly_reg - 1'b1;
                sec_next = sec_reg;
            end else if (dly_reg == CNT_W'(1)) begin
                dly_next = '0;
                sec_next = 1'b0;
            end
        end else begin
            dly_next = '0;
        end
        any_on = pri_reg || sec_reg;
        // feedback dynamic check
        edm_next = edm_reg;
        edm_cnt_next = edm_cnt_reg + 1'b1;
        edm_fail = 1'b0;
        code_next = code_reg;
        unique case (edm_reg)
            EDM_IDLE: begin
                edm_cnt_next = '0;
            end
            EDM_OPEN_CHK: begin
                if (!contactor_feedback_input) begin
                    edm_next = EDM_IDLE;
                end else if (edm_cnt_reg >= CNT_W'(EDM_CYC - 1)) begin
                    edm_fail = 1'b1;
                    code_next = ERR_EDM_OPEN;
                end
            end
            EDM_CLOSE_CHK: begin
                if (contactor_feedback_input) begin
                    edm_next = EDM_IDLE;
                end else if (edm_cnt_reg >= CNT_W'(EDM_CYC - 1)) begin
                    edm_fail = 1'b1;
                    code_next = ERR_EDM_CLOSE;
                end
            end
            default: begin
                edm_next = EDM_IDLE;
            end
        endcase
        if (edm_fail) begin
            pri_next = 1'b0;
            sec_next = 1'b0;
            dly_next = '0;
        end
        any_on_next = pri_next || sec_next;
        if (cfg.edm_en && any_on_next && !any_on) begin
            edm_next = EDM_OPEN_CHK;
            edm_cnt_next = '0;
        end else if (cfg.edm_en && !any_on_next && any_on) begin
            edm_next = EDM_CLOSE_CHK;
            edm_cnt_next = '0;
        end else if (edm_fail || !cfg.edm_en) begin
            edm_next = EDM_IDLE;
            edm_cnt_next = '0;
        end
        if (lnk_fail) begin
            code_next = ERR_LINK_SIM;
        end
        err_next = edm_fail || lnk_fail;
        // fault latch, a new feedback check failure wins over the clear
        fault_next = edm_fail || (fault_reg && !fault_clear);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pri_reg <= 1'b0;
            sec_reg <= 1'b0;
            dly_reg <= '0;
            edm_reg <= EDM_IDLE;
            edm_cnt_reg <= '0;
            fault_reg <= 1'b0;
            err_reg <= 1'b0;
            code_reg <= ERR_NONE;
        end else begin
            pri_reg <= pri_next;
            sec_reg <= sec_next;
            dly_reg <= dly_next;
            edm_reg <= edm_next;
            edm_cnt_reg <= edm_cnt_next;
            fault_reg <= fault_next;
            err_reg <= err_next;
            code_reg <= code_next;
        end
    end
    assign primary_safety_output_group = pri_reg;
    assign secondary_safety_output_group = sec_reg;
    assign fault_lock = fault_reg;
    assign err_pulse = err_reg;
    assign err_code = code_reg;

    // changeover detection and mapped indication outputs
    logic [NFSEL-1:0] fsel_reg;
    logic chg_a, chg_b, fsel_seen_reg, fsel_seen_next;
    sool_ind_t ind_reg, ind_next;
    logic [NSIG_OUT-1:0] sig_reg, sig_next;
    always_comb begin
        // no compare until one real sample is held, so reset gives no false change
        fsel_seen_next = 1'b1;
        chg_a = fsel_seen_reg && (field_select_inputs[4:0] != fsel_reg[4:0]);
        chg_b = fsel_seen_reg && (field_select_inputs[9:5] != fsel_reg[9:5]);
        ind_next.pf_viol = pf_violation[0] || (cfg.two_func && pf_violation[1]);
        ind_next.wf_viol = |wf_violation;
        ind_next.chg_act = chg_a || (cfg.two_func && chg_b);
        ind_next.outputs_on = pri_reg || sec_reg;
        ind_next.fault = fault_reg;
        ind_next.error = fault_reg || (lnk_reg == LNK_BAD);
        ind_next.warn = |wf_violation || (lnk_reg == LNK_WAIT);
        ind_next.diag = edm_reg != EDM_IDLE;
        for (int i = 0; i < NSIG_OUT; i++) begin
            sig_next[i] = ind_reg[sig_sel[i]];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fsel_reg <= '0;
            fsel_seen_reg <= 1'b0;
            ind_reg <= '0;
            sig_reg <= '0;
        end else begin
            fsel_reg <= field_select_inputs;
            fsel_seen_reg <= fsel_seen_next;
            ind_reg <= ind_next;
            sig_reg <= sig_next;
        end
    end
    assign ind = ind_reg;
    assign sig_out = sig_reg;

    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_contour_trip: assert property (contour_fault[0] |=> !pri_reg)
        else $error("contour fault left primary on");
    chk_standby_off: assert property (cfg.standby[0] && !cfg.two_func |=> !pri_reg && !sec_reg)
        else $error("standby left outputs on");
    chk_delay_time: assert property ($fell(pri_reg) && !cfg.two_func && cfg.delay_en
        && cfg_delay_cyc == 32'h4 && !fault_reg && !cfg.standby[0] && !edm_fail
        |-> sec_reg [*4] ##1 !sec_reg)
        else $error("secondary delay wrong");
    chk_restart_block: assert property (dly_reg != '0 |=> !$rose(pri_reg))
        else $error("restart during delay");
    chk_edm_gate: assert property (cfg.edm_en && !contactor_feedback_input && !any_on
        |=> !pri_reg && !sec_reg)
        else $error("switch-on with open feedback");
    chk_edm_open: assert property (edm_reg == EDM_OPEN_CHK && contactor_feedback_input
        && edm_cnt_reg == CNT_W'(EDM_CYC - 1) |=> fault_reg && !pri_reg && err_reg)
        else $error("open check timeout missed");
    chk_edm_close: assert property (edm_reg == EDM_CLOSE_CHK && !contactor_feedback_input
        && edm_cnt_reg == CNT_W'(EDM_CYC - 1) |=> fault_reg && code_reg == ERR_EDM_CLOSE)
        else $error("close check timeout missed");
    chk_link_ext: assert property (cfg.link_en && lnk_reg == LNK_CLOSED && !both_closed
        && pri_reg && demand_a && !edm_fail |=> pri_reg)
        else $error("linked switch-off not extended");
    chk_link_off: assert property (cfg.link_en && !link_ok |=> !pri_reg)
        else $error("upstream off ignored");
    chk_sim_error: assert property (lnk_reg == LNK_WAIT && !both_closed && !none_closed
        && sim_cnt_reg == CNT_W'(SIM_CYC - 1) |=> lnk_reg == LNK_BAD && err_reg)
        else $error("simultaneity error missed");
    chk_two_func: assert property (cfg.two_func && sec_reg && demand_b && !edm_fail
        |=> sec_reg)
        else $error("secondary dropped by other function");
    cov_switch_on: cover property ($rose(pri_reg));
    cov_delayed_off: cover property ($fell(sec_reg) && !pri_reg);
    cov_fault: cover property ($rose(fault_reg));
    cov_link_bad: cover property (lnk_reg == LNK_BAD);
endmodule
`default_nettype wire

// ==== test/sool_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sool_far_model (
    // clock
    input wire logic ref_clk,
    // safety outputs of the block
    input wire logic primary_on,
    input wire logic secondary_on,
    // commands from the bench
    input wire logic [1:0] fb_mode,
    input wire logic [7:0] fb_lag,
    input wire logic link_req,
    input wire logic [7:0] link_skew,
    // lines into the block
    output logic feedback,
    output logic [1:0] link_ch
);
    logic [7:0] fb_cnt;
    logic [7:0] sk_cnt;
    logic ch1_q;
    logic fb_target;

    // contactor released means feedback closed
    assign fb_target = !(primary_on || secondary_on);
    // first upstream channel follows at once, second after the skew
    assign link_ch = {ch1_q, link_req};

    initial begin
        feedback = 1'b1;
        fb_cnt = 8'h00;
        sk_cnt = 8'h00;
        ch1_q = 1'b0;
    end

    // contactor with lag; mode 1 sticks closed, 2 sticks open, 3 open
    always @(negedge ref_clk) begin
        if (fb_mode == 2'h3) begin
            feedback <= 1'b0;
        end else if (feedback == fb_target) begin
            fb_cnt <= 8'h00;
        end else if (fb_cnt + 8'h01 < fb_lag) begin
            fb_cnt <= fb_cnt + 8'h01;
        end else if (!(fb_mode == 2'h1 && !fb_target) && !(fb_mode == 2'h2 && fb_target)) begin
            feedback <= fb_target;
            fb_cnt <= 8'h00;
        end
    end

    // second channel trails the first
    always @(negedge ref_clk) begin
        if (ch1_q == link_req) begin
            sk_cnt <= 8'h00;
        end else if (sk_cnt + 8'h01 < link_skew) begin
            sk_cnt <= sk_cnt + 8'h01;
        end else begin
            ch1_q <= link_req;
            sk_cnt <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ==== test/safety_output_interlock_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module safety_output_interlock_control_tb;
    import sool_pkg::*;
    localparam int unsigned EDM_T = 20;
    localparam int unsigned LNK_T = 5;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    sool_cfg_t cfg = '0;
    logic [CNT_W-1:0] cfg_delay_cyc = '0;
    logic [NSIG_OUT-1:0][SEL_W-1:0] sig_sel = '0;
    logic [1:0] pf_violation = 2'h0;
    logic [1:0] wf_violation = 2'h0;
    logic [1:0][CONTOUR_W-1:0] contour_dev_mm = {12'h3e8, 12'h000};
    logic [NFSEL-1:0] field_select_inputs = 10'h001;
    logic fault_clear = 1'b0;
    logic contactor_feedback_input;
    logic [1:0] link_ch;
    logic primary, secondary, fault_lock, err_pulse, pulse_seen;
    logic [3:0] err_code;
    sool_ind_t ind;
    logic [NSIG_OUT-1:0] sig_out;
    logic [1:0] fb_mode = 2'h0;
    logic [7:0] fb_lag = 8'h03;
    logic link_req = 1'b0;
    logic [7:0] link_skew = 8'h03;
    logic [CONTOUR_W-1:0] dev;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_pf, n_link, d, i, cnt;

    sool_interlock #(.EDM_CYC(EDM_T), .SIM_CYC(20), .LINK_CYC(LNK_T)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .cfg(cfg), .cfg_delay_cyc(cfg_delay_cyc),
        .sig_sel(sig_sel), .pf_violation(pf_violation), .wf_violation(wf_violation),
        .contour_dev_mm(contour_dev_mm), .field_select_inputs(field_select_inputs),
        .contactor_feedback_input(contactor_feedback_input), .link_ch(link_ch),
        .fault_clear(fault_clear), .primary_safety_output_group(primary),
        .secondary_safety_output_group(secondary), .fault_lock(fault_lock),
        .err_pulse(err_pulse), .err_code(err_code), .ind(ind), .sig_out(sig_out));

    sool_far_model far (
        .ref_clk(ref_clk), .primary_on(primary), .secondary_on(secondary),
        .fb_mode(fb_mode), .fb_lag(fb_lag), .link_req(link_req), .link_skew(link_skew),
        .feedback(contactor_feedback_input), .link_ch(link_ch));

    // 125 MHz clock
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // bounded wait for the output pair
    task automatic wait_out(input logic [1:0] ps, input int lim);
        int k;
        k = 0;
        while ({primary, secondary} !== ps && k < lim) begin
            @(negedge ref_clk);
            k++;
        end
    endtask

    // cycles until the primary group drops
    task automatic meas_drop(output int n);
        n = 0;
        while (primary !== 1'b0 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // bounded wait for a new error pulse that carries the code
    task automatic wait_err(input logic [3:0] code, input int lim);
        int k;
        k = 0;
        pulse_seen = 1'b0;
        while (!(pulse_seen === 1'b1 && err_code === code) && k < lim) begin
            @(negedge ref_clk);
            if (err_pulse === 1'b1) pulse_seen = 1'b1;
            k++;
        end
    endtask

    function automatic logic contour_ok(input logic [CONTOUR_W-1:0] mm);
        return mm <= CONTOUR_TOL_MM;
    endfunction

    task automatic end_sim;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        cyc(20000);
        n_mismatch++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h5724));
        cyc(20);
        rstn = 1'b1;
        // no false changeover flag out of reset
        pulse_seen = 1'b0;
        repeat (6) begin
            @(negedge ref_clk);
            if (ind.chg_act === 1'b1) pulse_seen = 1'b1;
        end
        chk(pulse_seen, 1'b0);
        // delayed secondary group, restart held off meanwhile
        cfg.delay_en = 1'b1;
        for (i = 0; i < 3; i++) begin
            d = (i == 0) ? 1 : ((i == 1) ? 4 : $urandom_range(12, 2));
            cfg_delay_cyc = d;
            wait_out(2'b11, 30);
            chk({primary, secondary}, 2'b11);
            pf_violation = 2'h1;
            meas_drop(n_pf);
            pf_violation = 2'h0;
            cnt = 0;
            while (secondary === 1'b1 && cnt < 100) begin
                @(negedge ref_clk);
                cnt++;
                if (secondary === 1'b1) chk(primary, 1'b0);
            end
            chk(cnt, d);
            wait_out(2'b11, 20);
            chk({primary, secondary}, 2'b11);
        end
        // contour tolerance, corners then random
        cfg.contour_en = 2'h1;
        for (i = 0; i < 14; i++) begin
            dev = (i == 0) ? 12'h0c8 : ((i == 1) ? 12'h0c9 : CONTOUR_W'($urandom_range(260, 140)));
            contour_dev_mm[0] = dev;
            // restart after a trip waits for the running delay
            cyc(20);
            chk(primary, contour_ok(dev));
        end
        contour_dev_mm[0] = 12'h000;
        // standby drops both at once despite the delay
        cfg_delay_cyc = 32'h8;
        cfg.standby = 2'h1;
        cyc(3);
        chk({primary, secondary}, 2'b00);
        cfg.standby = 2'h0;
        wait_out(2'b11, 20);
        chk({primary, secondary}, 2'b11);
        cfg.delay_en = 1'b0;
        // two independent functions
        cfg.two_func = 1'b1;
        pf_violation = 2'h2;
        cyc(4);
        chk({primary, secondary}, 2'b10);
        pf_violation = 2'h1;
        cyc(4);
        chk({primary, secondary}, 2'b01);
        cfg.two_func = 1'b0;
        // indication mapping and changeover flag
        sig_sel = {3'h4, 3'h3, 3'h6, 3'h7};
        cyc(4);
        chk(sig_out, 4'h1);
        wf_violation = 2'h1;
        cyc(4);
        chk(sig_out, 4'h3);
        wf_violation = 2'h0;
        field_select_inputs = 10'h020;
        pulse_seen = 1'b0;
        repeat (4) begin
            @(negedge ref_clk);
            if (ind.chg_act === 1'b1) pulse_seen = 1'b1;
        end
        chk(pulse_seen, 1'b1);
        // contactor feedback monitoring
        cfg.edm_en = 1'b1;
        cyc(5);
        pf_violation = 2'h0;
        wait_out(2'b11, 20);
        chk({primary, secondary}, 2'b11);
        cyc(EDM_T + 10);
        chk({fault_lock, primary}, 2'b01);
        pf_violation = 2'h1;
        cyc(EDM_T + 10);
        chk({fault_lock, primary}, 2'b00);
        fb_mode = 2'h3;
        cyc(5);
        pf_violation = 2'h0;
        cyc(10);
        chk(primary, 1'b0);
        fb_mode = 2'h1;
        wait_out(2'b11, 20);
        chk({primary, secondary}, 2'b11);
        wait_err(ERR_EDM_OPEN, EDM_T + 10);
        chk({fault_lock, pulse_seen, primary, secondary}, 4'hc);
        chk(err_code, ERR_EDM_OPEN);
        fb_mode = 2'h0;
        cyc(5);
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        wait_out(2'b11, 20);
        chk({fault_lock, primary}, 2'b01);
        cyc(6);
        fb_mode = 2'h2;
        pf_violation = 2'h1;
        wait_err(ERR_EDM_CLOSE, EDM_T + 10);
        chk({fault_lock, pulse_seen}, 2'b11);
        chk(err_code, ERR_EDM_CLOSE);
        fb_mode = 2'h0;
        cyc(6);
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cfg.edm_en = 1'b0;
        // upstream linkage, contact and electronic
        for (i = 0; i < 2; i++) begin
            pf_violation = 2'h1;
            link_req = 1'b0;
            link_skew = 8'h03;
            cfg.link_en = 1'b1;
            cfg.link_elec = i[0];
            cyc(30);
            pf_violation = 2'h0;
            cyc(10);
            chk(primary, 1'b0);
            link_req = 1'b1;
            wait_out(2'b11, 30);
            chk({primary, secondary}, 2'b11);
            cyc(5);
            link_req = 1'b0;
            meas_drop(n_link);
            // link state register adds one cycle ahead of the extension
            chk(n_link, n_pf + LNK_T + 1);
            link_skew = 8'h19;
            cyc(30);
            link_req = 1'b1;
            wait_err(ERR_LINK_SIM, 40);
            chk({err_code, pulse_seen}, {ERR_LINK_SIM, 1'b1});
            cyc(10);
            chk(primary, 1'b0);
            link_req = 1'b0;
            cyc(30);
            link_skew = 8'h01;
            link_req = 1'b1;
            wait_out(2'b11, 30);
            chk({primary, secondary}, 2'b11);
        end
        cfg.link_en = 1'b0;
        end_sim();
    end
endmodule
`default_nettype wire
